// >>> core/pioc_consts.vh
// Constants for the port configuration, data and pin-match block.
`ifndef PIOC_CONSTS_VH
`define PIOC_CONSTS_VH

// ****************************************************************
// Register addresses (8-bit special function register space)
// ****************************************************************
`define PIOC_ADDR_PORT2_DATA 8'hA0
`define PIOC_ADDR_PORT1_OUTPUT_DRIVE 8'hA5
`define PIOC_ADDR_PORT2_OUTPUT_DRIVE 8'hA6
`define PIOC_ADDR_PORT3_OUTPUT_DRIVE 8'hAF
`define PIOC_ADDR_PORT3_DATA 8'hB0
`define PIOC_ADDR_PORT2_COMPARE_VALUE 8'hB1
`define PIOC_ADDR_PORT2_COMPARE_SELECT 8'hB2
`define PIOC_ADDR_PORT1_CROSSBAR_BYPASS 8'hD5
`define PIOC_ADDR_PORT2_CROSSBAR_BYPASS 8'hD6
`define PIOC_ADDR_PORT1_COMPARE_VALUE 8'hE1
`define PIOC_ADDR_PORT1_COMPARE_SELECT 8'hE2
`define PIOC_ADDR_PORT1_ANALOG_SELECT 8'hF2
`define PIOC_ADDR_PORT2_ANALOG_SELECT 8'hF3
`define PIOC_ADDR_PORT3_ANALOG_SELECT 8'hF4

// ****************************************************************
// Register pages
// ****************************************************************
`define PIOC_PAGE_0 4'h0
`define PIOC_PAGE_F 4'hF

// ****************************************************************
// Reset values
// ****************************************************************
`define PIOC_RST_DATA 8'hFF
`define PIOC_RST_ANALOG_SELECT 8'hFF
`define PIOC_RST_OUTPUT_DRIVE 8'h00
`define PIOC_RST_CROSSBAR_BYPASS 8'h00
`define PIOC_RST_COMPARE_VALUE 8'hFF
`define PIOC_RST_COMPARE_SELECT 8'h00

// ****************************************************************
// Widths
// ****************************************************************
`define PIOC_PORT_W 8
`define PIOC_SYNC_STAGES 2

`endif

// >>> core/pioc_sync.v
// Two-stage synchroniser for a bank of asynchronous pin levels.
`timescale 1ns/1ps

module pioc_sync (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Asynchronous pin levels.
	input wire [7:0] async_in,
	// Levels safe to use in the clock domain.
	output wire [7:0] sync_out
);

	reg [7:0] meta_ff;
	reg [7:0] sync_ff;

	// The first stage feeds only the second, so no logic sees a
	// metastable value.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 8'h00;
			sync_ff <= 8'h00;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // pioc_sync

// >>> core/pioc_pad_drive.v
// Per-pin output driver control for one 8-bit port.
`timescale 1ns/1ps

module pioc_pad_drive (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Port configuration.
	input wire [7:0] latch,
	input wire [7:0] analog_select,
	input wire [7:0] output_drive,
	// Pad controls, all registered.
	output reg [7:0] pin_out,
	output reg [7:0] pin_oe,
	output reg [7:0] pullup_en
);

	genvar i;

	// One driver cell per pin; every output is a flip-flop.
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_pin
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_out[i] <= 1'b1;
					pin_oe[i] <= 1'b0;
					pullup_en[i] <= 1'b1;
				end else begin
					// A latched value drives its level.
					pin_out[i] <= latch[i]; // RULE9
					// Analog pins never drive and ignore the drive
					// mode; open drain floats a high.
					pin_oe[i] <= analog_select[i] &
						(~latch[i] | output_drive[i]); // RULE1 RULE2 RULE3 RULE10
					// Analog pins lose their weak pullup.
					pullup_en[i] <= analog_select[i]; // RULE1
				end
			end
		end
	endgenerate

endmodule // pioc_pad_drive

// >>> core/pioc_port_io_config_and_match.v
// Configuration for three GPIO ports, data latches for ports 2 and 3, and pin-match logic for ports 1 and 2.
//
// Summary of operation
// RULE1: Input-mode 0 makes pin analog; resets to ones.
// RULE2: Output mode ignored while pin is analog.
// RULE3: Output mode 0 open-drain, 1 push-pull; reset 0.
// RULE4: Bypass bit 1 makes crossbar skip pin.
// RULE5: Software bypasses analog and special-function pins.
// RULE6: Masked pins differing from compare raise match.
// RULE7: Select bit 0 excludes pin from comparison.
// RULE8: Compare values reset ones, selects reset zeros.
// RULE9: Written data latch drives pin level.
// RULE10: Open-drain high latch leaves pin floating.
// RULE11: Analog pins read back as zero.
// RULE12: Digital pins read back present level.
// RULE13: Data registers on all pages, bit writable.
// RULE14: Match requests interrupt when enabled; wakes oscillator.
// RULE15: Read-modify-write reads the latch, not pins.
// RULE16: Match is OR of ports, every cycle.
`timescale 1ns/1ps
`include "pioc_consts.vh"

module pioc_port_io_config_and_match (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Register port: byte access.
	input wire [7:0] sfr_addr,
	input wire [3:0] sfr_page,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire sfr_rd,
	input wire sfr_rmw,
	// Register port: single-bit write of a data register.
	input wire sfr_bit_wr,
	input wire [2:0] sfr_bit_sel,
	input wire sfr_bit_val,
	// Register port: read answer.
	output reg [7:0] sfr_rdata,
	// Interrupt enable from the extended enable register.
	input wire match_interrupt_enable,
	// Asynchronous pin levels.
	input wire [7:0] port1_pins,
	input wire [7:0] port2_pins,
	input wire [7:0] port3_pins,
	// Port 2 pad controls.
	output wire [7:0] port2_pin_out,
	output wire [7:0] port2_pin_oe,
	output wire [7:0] port2_pullup_en,
	// Port 3 pad controls.
	output wire [7:0] port3_pin_out,
	output wire [7:0] port3_pin_oe,
	output wire [7:0] port3_pullup_en,
	// Port 1 pad configuration and port 1 and port 2 crossbar skips.
	output reg [7:0] port1_digital_en,
	output reg [7:0] port1_push_pull,
	output reg [7:0] port1_pullup_en,
	output reg [7:0] port1_skip,
	output reg [7:0] port2_skip,
	// Match results.
	output reg port_match,
	output reg match_irq,
	output reg osc_wake
);

	// ************************************************************
	// Registers
	// ************************************************************
	reg [7:0] port2_data_ff;
	reg [7:0] port3_data_ff;
	reg [7:0] port1_analog_select_ff;
	reg [7:0] port2_analog_select_ff;
	reg [7:0] port3_analog_select_ff;
	reg [7:0] port1_output_drive_ff;
	reg [7:0] port2_output_drive_ff;
	reg [7:0] port3_output_drive_ff;
	reg [7:0] port1_crossbar_bypass_ff;
	reg [7:0] port2_crossbar_bypass_ff;
	reg [7:0] port1_compare_value_ff;
	reg [7:0] port2_compare_value_ff;
	reg [7:0] port1_compare_select_ff;
	reg [7:0] port2_compare_select_ff;

	wire [7:0] port1_sync;
	wire [7:0] port2_sync;
	wire [7:0] port3_sync;

	reg [7:0] nxt_rdata;
	reg [7:0] bit_mask;
	wire page_f;
	wire page_0;
	wire wr_byte;
	wire [7:0] port1_level;
	wire [7:0] port2_level;
	wire [7:0] port3_level;
	wire port1_miss;
	wire port2_miss;
	wire nxt_match;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************

	// Pins are asynchronous, so each bank passes two flip-flops.
	pioc_sync u_sync_p1 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(port1_pins),
		.sync_out(port1_sync)
	);

	pioc_sync u_sync_p2 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(port2_pins),
		.sync_out(port2_sync)
	);

	pioc_sync u_sync_p3 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(port3_pins),
		.sync_out(port3_sync)
	);

	// Analog pins have their digital receiver off and read as zero.
	assign port1_level = port1_sync & port1_analog_select_ff; // RULE1
	assign port2_level = port2_sync & port2_analog_select_ff; // RULE11 RULE12
	assign port3_level = port3_sync & port3_analog_select_ff; // RULE11 RULE12

	// ************************************************************
	// Address decode
	// ************************************************************

	// Configuration registers live on page F, the port 2 compare
	// registers on page 0; the data registers answer on every page.
	assign page_f = (sfr_page == `PIOC_PAGE_F);
	assign page_0 = (sfr_page == `PIOC_PAGE_0);
	assign wr_byte = sfr_wr & ~sfr_bit_wr;

	// One-hot mask of the bit addressed by a bit write.
	always @* begin
		bit_mask = 8'h00;
		bit_mask[sfr_bit_sel] = 1'b1;
	end

	// ************************************************************
	// Data latches
	// ************************************************************

	// A bit write modifies the latch, never the pin levels, so a
	// pin held low by another driver cannot corrupt its neighbours.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port2_data_ff <= `PIOC_RST_DATA; // RULE13
			port3_data_ff <= `PIOC_RST_DATA; // RULE13
		end else begin
			if (sfr_addr == `PIOC_ADDR_PORT2_DATA) begin
				if (wr_byte) begin
					port2_data_ff <= sfr_wdata; // RULE9 RULE13
				end else if (sfr_bit_wr) begin
					port2_data_ff <= sfr_bit_val ?
						(port2_data_ff | bit_mask) :
						(port2_data_ff & ~bit_mask); // RULE13 RULE15
				end
			end
			if (sfr_addr == `PIOC_ADDR_PORT3_DATA) begin
				if (wr_byte) begin
					port3_data_ff <= sfr_wdata; // RULE9 RULE13
				end else if (sfr_bit_wr) begin
					port3_data_ff <= sfr_bit_val ?
						(port3_data_ff | bit_mask) :
						(port3_data_ff & ~bit_mask); // RULE13 RULE15
				end
			end
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************

	// Byte writes only; these registers are not bit addressable.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_analog_select_ff <= `PIOC_RST_ANALOG_SELECT; // RULE1
			port2_analog_select_ff <= `PIOC_RST_ANALOG_SELECT; // RULE1
			port3_analog_select_ff <= `PIOC_RST_ANALOG_SELECT; // RULE1
			port1_output_drive_ff <= `PIOC_RST_OUTPUT_DRIVE; // RULE3
			port2_output_drive_ff <= `PIOC_RST_OUTPUT_DRIVE; // RULE3
			port3_output_drive_ff <= `PIOC_RST_OUTPUT_DRIVE; // RULE3
			port1_crossbar_bypass_ff <= `PIOC_RST_CROSSBAR_BYPASS; // RULE4
			port2_crossbar_bypass_ff <= `PIOC_RST_CROSSBAR_BYPASS; // RULE4
			port1_compare_value_ff <= `PIOC_RST_COMPARE_VALUE; // RULE8
			port2_compare_value_ff <= `PIOC_RST_COMPARE_VALUE; // RULE8
			port1_compare_select_ff <= `PIOC_RST_COMPARE_SELECT; // RULE8
			port2_compare_select_ff <= `PIOC_RST_COMPARE_SELECT; // RULE8
		end else if (wr_byte && page_f) begin
			case (sfr_addr)
			`PIOC_ADDR_PORT1_ANALOG_SELECT: begin
				port1_analog_select_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT2_ANALOG_SELECT: begin
				port2_analog_select_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT3_ANALOG_SELECT: begin
				port3_analog_select_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT1_OUTPUT_DRIVE: begin
				port1_output_drive_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT2_OUTPUT_DRIVE: begin
				port2_output_drive_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT3_OUTPUT_DRIVE: begin
				port3_output_drive_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT1_CROSSBAR_BYPASS: begin
				port1_crossbar_bypass_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT2_CROSSBAR_BYPASS: begin
				port2_crossbar_bypass_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT1_COMPARE_VALUE: begin
				port1_compare_value_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT1_COMPARE_SELECT: begin
				port1_compare_select_ff <= sfr_wdata;
			end
			default: begin
			end
			endcase
		end else if (wr_byte && page_0) begin
			case (sfr_addr)
			`PIOC_ADDR_PORT2_COMPARE_VALUE: begin
				port2_compare_value_ff <= sfr_wdata;
			end
			`PIOC_ADDR_PORT2_COMPARE_SELECT: begin
				port2_compare_select_ff <= sfr_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************

	// Data registers return pin levels, or the latch during a
	// read-modify-write; unmapped addresses read as zero.
	always @* begin
		nxt_rdata = 8'h00;
		if (sfr_addr == `PIOC_ADDR_PORT2_DATA) begin
			nxt_rdata = sfr_rmw ? port2_data_ff : port2_level; // RULE11 RULE12 RULE15
		end else if (sfr_addr == `PIOC_ADDR_PORT3_DATA) begin
			nxt_rdata = sfr_rmw ? port3_data_ff : port3_level; // RULE11 RULE12 RULE15
		end else if (page_f) begin
			case (sfr_addr)
			`PIOC_ADDR_PORT1_ANALOG_SELECT: begin
				nxt_rdata = port1_analog_select_ff;
			end
			`PIOC_ADDR_PORT2_ANALOG_SELECT: begin
				nxt_rdata = port2_analog_select_ff;
			end
			`PIOC_ADDR_PORT3_ANALOG_SELECT: begin
				nxt_rdata = port3_analog_select_ff;
			end
			`PIOC_ADDR_PORT1_OUTPUT_DRIVE: begin
				nxt_rdata = port1_output_drive_ff;
			end
			`PIOC_ADDR_PORT2_OUTPUT_DRIVE: begin
				nxt_rdata = port2_output_drive_ff;
			end
			`PIOC_ADDR_PORT3_OUTPUT_DRIVE: begin
				nxt_rdata = port3_output_drive_ff;
			end
			`PIOC_ADDR_PORT1_CROSSBAR_BYPASS: begin
				nxt_rdata = port1_crossbar_bypass_ff;
			end
			`PIOC_ADDR_PORT2_CROSSBAR_BYPASS: begin
				nxt_rdata = port2_crossbar_bypass_ff;
			end
			`PIOC_ADDR_PORT1_COMPARE_VALUE: begin
				nxt_rdata = port1_compare_value_ff;
			end
			`PIOC_ADDR_PORT1_COMPARE_SELECT: begin
				nxt_rdata = port1_compare_select_ff;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
			endcase
		end else if (page_0) begin
			case (sfr_addr)
			`PIOC_ADDR_PORT2_COMPARE_VALUE: begin
				nxt_rdata = port2_compare_value_ff;
			end
			`PIOC_ADDR_PORT2_COMPARE_SELECT: begin
				nxt_rdata = port2_compare_select_ff;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
			endcase
		end
	end

	// Read data is registered and holds until the next read.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= nxt_rdata;
		end
	end

	// ************************************************************
	// Pin match
	// ************************************************************

	// A masked-off pin drops out of both sides of the compare.
	assign port1_miss = |((port1_level ^ port1_compare_value_ff) &
		port1_compare_select_ff); // RULE6 RULE7
	assign port2_miss = |((port2_level ^ port2_compare_value_ff) &
		port2_compare_select_ff); // RULE6 RULE7
	assign nxt_match = port1_miss | port2_miss; // RULE16

	// The match is a level, re-evaluated every cycle; it wakes the
	// oscillator regardless of the interrupt enable.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_match <= 1'b0;
			match_irq <= 1'b0;
			osc_wake <= 1'b0;
		end else begin
			port_match <= nxt_match; // RULE6 RULE16
			match_irq <= nxt_match & match_interrupt_enable; // RULE14
			osc_wake <= nxt_match; // RULE14
		end
	end

	// ************************************************************
	// Pad and crossbar controls
	// ************************************************************

	// Port 1 has no data latch here; its pad settings leave as flops.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port1_digital_en <= `PIOC_RST_ANALOG_SELECT;
			port1_push_pull <= `PIOC_RST_OUTPUT_DRIVE;
			port1_pullup_en <= `PIOC_RST_ANALOG_SELECT;
			port1_skip <= `PIOC_RST_CROSSBAR_BYPASS;
			port2_skip <= `PIOC_RST_CROSSBAR_BYPASS;
		end else begin
			port1_digital_en <= port1_analog_select_ff; // RULE1
			port1_push_pull <= port1_output_drive_ff &
				port1_analog_select_ff; // RULE2 RULE3
			port1_pullup_en <= port1_analog_select_ff; // RULE1
			port1_skip <= port1_crossbar_bypass_ff; // RULE4
			port2_skip <= port2_crossbar_bypass_ff; // RULE4
		end
	end

	pioc_pad_drive u_pad_p2 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.latch(port2_data_ff),
		.analog_select(port2_analog_select_ff),
		.output_drive(port2_output_drive_ff),
		.pin_out(port2_pin_out),
		.pin_oe(port2_pin_oe),
		.pullup_en(port2_pullup_en)
	);

	pioc_pad_drive u_pad_p3 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.latch(port3_data_ff),
		.analog_select(port3_analog_select_ff),
		.output_drive(port3_output_drive_ff),
		.pin_out(port3_pin_out),
		.pin_oe(port3_pin_oe),
		.pullup_en(port3_pullup_en)
	);

endmodule // pioc_port_io_config_and_match

// >>> bench/pioc_port_io_config_and_match_monitor.sv
// Port-level assertions for the port configuration and match block.
`timescale 1ns/1ps
module pioc_port_io_config_and_match_monitor (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Register port.
	input wire [7:0] sfr_addr,
	input wire [3:0] sfr_page,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire sfr_rd,
	input wire sfr_rmw,
	input wire sfr_bit_wr,
	input wire [2:0] sfr_bit_sel,
	input wire sfr_bit_val,
	input wire [7:0] sfr_rdata,
	input wire match_interrupt_enable,
	// Pad, crossbar and match outputs.
	input wire [7:0] port2_pin_out,
	input wire [7:0] port2_pin_oe,
	input wire [7:0] port2_pullup_en,
	input wire [7:0] port3_pin_out,
	input wire [7:0] port3_pin_oe,
	input wire [7:0] port3_pullup_en,
	input wire [7:0] port1_digital_en,
	input wire [7:0] port1_push_pull,
	input wire [7:0] port1_skip,
	input wire port_match,
	input wire match_irq,
	input wire osc_wake
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// A byte write reaches the pad two edges after its strobe.
	a_latch_drives_pad: assert property (
		sfr_wr && !sfr_bit_wr && sfr_addr == 8'hA0 |-> ##2
		port2_pin_out == $past(sfr_wdata, 2)) else $error("pad value wrong");
	a_bit_write_lands: assert property (
		sfr_bit_wr && sfr_addr == 8'hB0 |-> ##2
		port3_pin_out[$past(sfr_bit_sel, 2)] == $past(sfr_bit_val, 2))
		else $error("bit write lost");
	// An analog pin has its pullup off, so it must never be driven.
	a_analog_undriven: assert property (
		((port2_pin_oe & ~port2_pullup_en) |
		(port3_pin_oe & ~port3_pullup_en)) == 8'h00)
		else $error("analog pin driven");
	a_push_pull_gated: assert property (
		(port1_push_pull & ~port1_digital_en) == 8'h00)
		else $error("push-pull on analog pin");
	a_mode_write: assert property (
		sfr_wr && !sfr_bit_wr && sfr_addr == 8'hF2 && sfr_page == 4'hF
		##1 !sfr_wr |=> port1_digital_en == $past(sfr_wdata, 2))
		else $error("input mode not written");
	a_mode_holds: assert property (
		!(sfr_wr && sfr_addr == 8'hF2 && sfr_page == 4'hF) [*3]
		|-> $stable(port1_digital_en)) else $error("input mode changed");
	a_skip_write: assert property (
		sfr_wr && !sfr_bit_wr && sfr_addr == 8'hD5 && sfr_page == 4'hF
		##1 !sfr_wr |=> port1_skip == $past(sfr_wdata, 2))
		else $error("skip not written");
	a_irq_gated: assert property (
		match_irq == (port_match & $past(match_interrupt_enable)))
		else $error("match request wrong");
	a_wake_follows: assert property (
		osc_wake == port_match) else $error("wake differs from match");
	// A read-modify-write read returns the latch, which the pad mirrors.
	a_rmw_latch: assert property (
		sfr_rd && sfr_rmw && sfr_addr == 8'hA0 && !$past(sfr_wr) &&
		!$past(sfr_bit_wr) |=> sfr_rdata == $past(port2_pin_out))
		else $error("rmw read not latch");
endmodule // pioc_port_io_config_and_match_monitor

bind pioc_port_io_config_and_match pioc_port_io_config_and_match_monitor
	u_mon (.*);

// >>> bench/pioc_pin_model.sv
// Behavioural model of the circuit on the pins of one 8-bit port.
`timescale 1ns/1ps
module pioc_pin_model (
	// Clock for the floating-line pattern.
	input wire core_clk,
	// Device pad controls.
	input wire [7:0] pin_out,
	input wire [7:0] pin_oe,
	input wire [7:0] pullup_en,
	// External driver.
	input wire [7:0] ext_val,
	input wire [7:0] ext_en,
	// Resolved line levels.
	output logic [7:0] pin_level
);
	// ****************************************************************
	// Line resolution
	// ****************************************************************
	logic float_ff = 1'b0;
	// A line nobody holds flips every cycle, so no stale level passes.
	always @(posedge core_clk) begin
		float_ff <= ~float_ff;
	end
	// Device drive wins, then the external driver, then the pullup.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_level[i] = pin_out[i];
			else if (ext_en[i])
				pin_level[i] = ext_val[i];
			else if (pullup_en[i])
				pin_level[i] = 1'b1;
			else
				pin_level[i] = float_ff;
		end
	end
endmodule // pioc_pin_model

// >>> bench/pioc_port_io_config_and_match_tb.sv
// Self-checking bench for the port configuration and match block.
`timescale 1ns/1ps
module pioc_port_io_config_and_match_tb;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic core_clk = 1'b0, rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [3:0] sfr_page = 4'h0;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
	logic sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic match_interrupt_enable = 1'b0;
	logic [7:0] port1_pins = 8'hFF, port2_pins, port3_pins;
	logic [7:0] port2_pin_out, port2_pin_oe, port2_pullup_en;
	logic [7:0] port3_pin_out, port3_pin_oe, port3_pullup_en;
	logic [7:0] port1_digital_en, port1_push_pull, port1_pullup_en;
	logic [7:0] port1_skip, port2_skip;
	logic port_match, match_irq, osc_wake;
	logic [7:0] ext3_val = 8'h00, ext3_en = 8'h00, a_v, r_v;
	logic [3:0] p_v;
	int err_total = 0, checks = 0, cycles = 0;
	// Configuration addresses and reset values, first entry in the top byte.
	localparam [95:0] CFG_A = 96'hA5A6AFB1B2D5D6E1E2F2F3F4;
	localparam [95:0] CFG_R = 96'h000000FF000000FF00FFFFFF;

	pioc_port_io_config_and_match dut (.*);
	pioc_pin_model u_p2 (.core_clk(core_clk), .pin_out(port2_pin_out),
		.pin_oe(port2_pin_oe), .pullup_en(port2_pullup_en),
		.ext_val(8'h00), .ext_en(8'h00), .pin_level(port2_pins));
	pioc_pin_model u_p3 (.core_clk(core_clk), .pin_out(port3_pin_out),
		.pin_oe(port3_pin_oe), .pullup_en(port3_pullup_en),
		.ext_val(ext3_val), .ext_en(ext3_en), .pin_level(port3_pins));

	// Clock at 40 MHz.
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	// A hang is cut short well past the expected run length.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	// Each access waits for a fresh edge, so strobes never re-rise at once.
	task automatic wr(input logic [7:0] a, input logic [3:0] p,
		input logic [7:0] d);
		idle(1);
		{sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {a, p, d, 1'b1};
		idle(1);
		sfr_wr = 1'b0;
	endtask
	task automatic bwr(input logic [7:0] a, input logic [3:0] p,
		input logic [2:0] s, input logic v);
		idle(1);
		{sfr_addr, sfr_page, sfr_bit_sel, sfr_bit_val} = {a, p, s, v};
		sfr_bit_wr = 1'b1;
		idle(1);
		sfr_bit_wr = 1'b0;
	endtask
	task automatic rdck(input string nm, input logic [7:0] a,
		input logic [3:0] p, input logic m, input logic [7:0] exp);
		idle(1);
		{sfr_addr, sfr_page, sfr_rmw, sfr_rd} = {a, p, m, 1'b1};
		idle(1);
		{sfr_rmw, sfr_rd} = 2'b00;
		chk(nm, exp, sfr_rdata);
	endtask
	task automatic wmatch(input logic exp);
		for (int n = 0; n < 8 && port_match !== exp; n++)
			idle(1);
		chk("port_match", {7'h00, exp}, {7'h00, port_match});
	endtask

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		idle(10);
		rst_n = 1'b1;
		// Pin levels need two edges through the synchroniser first.
		idle(2);
		chk("port2_pin_oe reset", 8'h00, port2_pin_oe);
		chk("port3_pullup_en reset", 8'hFF, port3_pullup_en);
		rdck("port2_data reset", 8'hA0, 4'h0, 1'b0, 8'hFF);
		rdck("port3_data reset", 8'hB0, 4'h7, 1'b1, 8'hFF);
		rdck("unmapped", 8'h00, 4'hF, 1'b0, 8'h00);
		for (int i = 11; i >= 0; i--) begin
			a_v = CFG_A[8 * i +: 8];
			r_v = CFG_R[8 * i +: 8];
			p_v = (a_v == 8'hB1 || a_v == 8'hB2) ? 4'h0 : 4'hF;
			rdck("reset value", a_v, p_v, 1'b0, r_v);
			wr(a_v, p_v ^ 4'h5, 8'h99);
			rdck("wrong page", a_v, p_v, 1'b0, r_v);
			wr(a_v, p_v, 8'h3C + 8'(i));
			rdck("read back", a_v, p_v, 1'b0, 8'h3C + 8'(i));
			wr(a_v, p_v, r_v);
		end
		// Low pins analog, so software also takes them off the crossbar.
		wr(8'hF2, 4'hF, 8'hF0);
		wr(8'hA5, 4'hF, 8'hFF);
		wr(8'hD5, 4'hF, 8'h0F);
		wr(8'hD6, 4'hF, 8'h0F);
		idle(2);
		chk("port1_push_pull", 8'hF0, port1_push_pull);
		chk("port1_pullup_en", 8'hF0, port1_pullup_en);
		chk("port2_skip", 8'h0F, port2_skip);
		wr(8'hF2, 4'hF, 8'hFF);
		// Half push-pull, latch 55: open-drain ones must float.
		wr(8'hA6, 4'hF, 8'h0F);
		wr(8'hA0, 4'h3, 8'h55);
		idle(2);
		chk("port2_pin_oe", 8'hAF, port2_pin_oe);
		chk("port2_pin_out", 8'h55, port2_pin_out);
		wr(8'hF3, 4'hF, 8'hF0);
		idle(2);
		chk("port2_pin_oe analog", 8'hA0, port2_pin_oe);
		chk("port2_pullup_en", 8'hF0, port2_pullup_en);
		rdck("port2 pins", 8'hA0, 4'h0, 1'b0, 8'h50);
		rdck("port2 latch", 8'hA0, 4'h0, 1'b1, 8'h55);
		bwr(8'hB0, 4'h9, 3'd2, 1'b0);
		bwr(8'hA6, 4'hF, 3'd7, 1'b1);
		rdck("bit write refused", 8'hA6, 4'hF, 1'b0, 8'h0F);
		chk("port3_pin_out", 8'hFB, port3_pin_out);
		chk("port3_pin_oe", 8'h04, port3_pin_oe);
		{ext3_en, ext3_val} = {8'hFB, 8'h3C};
		idle(3);
		rdck("port3 pins", 8'hB0, 4'h0, 1'b0, 8'h38);
		wr(8'hF4, 4'hF, 8'h0F);
		idle(3);
		rdck("port3 analog", 8'hB0, 4'h0, 1'b0, 8'h08);
		rdck("port3 latch", 8'hB0, 4'h0, 1'b1, 8'hFB);
		// Pin change against compare values, then mask and enable play.
		wmatch(1'b0);
		wr(8'hE2, 4'hF, 8'h01);
		port1_pins = 8'hFE;
		match_interrupt_enable = 1'b1;
		wmatch(1'b1);
		chk("match_irq", 8'h01, {7'h00, match_irq});
		chk("osc_wake", 8'h01, {7'h00, osc_wake});
		match_interrupt_enable = 1'b0;
		idle(2);
		chk("match_irq off", 8'h00, {7'h00, match_irq});
		wr(8'hE2, 4'hF, 8'h02);
		wmatch(1'b0);
		wr(8'hB2, 4'h0, 8'h80);
		wmatch(1'b1);
		wr(8'hB1, 4'h0, 8'h7F);
		wmatch(1'b0);
		tally_and_finish();
	end
endmodule // pioc_port_io_config_and_match_tb
